// File: logic/ivcf_map.svh
`ifndef IVCF_MAP_SVH
`define IVCF_MAP_SVH
// Register offsets (word addresses on the plain port)
`define IVCF_ADDR_FLAGS 8'h06
`define IVCF_ADDR_VALID 8'h07
// Reset value of the change flags
`define IVCF_FLAGS_RST 8'hFF
// Field positions of the inputs
`define IVCF_BIT_INPUT_ONE 0
`define IVCF_BIT_INPUT_EIGHT 7
`endif

// File: logic/ivcf_pkg.sv
`default_nettype none
package ivcf_pkg;
   typedef logic [7:0] ivcf_byte_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ivcf_req_s;
endpackage
`default_nettype wire

// File: logic/ivcf_flag_bit.sv
`timescale 1ns/1ps
`default_nettype none
// One sticky change flag with write-one-to-clear
module ivcf_flag_bit #(
   parameter logic RST_VAL = 1'b1
) (
   input wire logic clk, // System clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic valid_in, // Validity level of this input
   input wire logic clr, // Software clear pulse
   output logic flag, // Sticky change flag
   output logic valid_seen // Registered validity level
);
   logic valid_r;
   logic flag_r;
   logic change;
   // Either direction of validity counts as a change
   assign change = valid_in ^ valid_r;
   // Set wins over clear; flag holds until cleared
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         valid_r <= 1'b0;
         flag_r <= RST_VAL;
      end else begin
         valid_r <= valid_in;
         if (change) begin
            flag_r <= 1'b1;
         end else if (clr) begin
            flag_r <= 1'b0;
         end
      end
   end
   assign flag = flag_r;
   assign valid_seen = valid_r;
endmodule
`default_nettype wire

// File: logic/ivcf_top.sv
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ivcf_map.svh"
// How it works
// - Flag bits 7 down to 0 belong to reference inputs eight down to one.
// - A flag sets whenever its input goes valid or goes invalid.
// - A set flag stays one, even if validity reverts, until cleared.
// - Writing one to a bit clears it, unless its input changes in the same cycle; bits written zero are untouched.
// - Reading gives zero for no change since the clear, one for a change.
module ivcf_top
   import ivcf_pkg::*;
#(
   parameter int NUM_IN = 8
) (
   input wire logic clk, // 40 MHz system clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic [NUM_IN-1:0] ref_valid, // Validity per input
   input wire logic [7:0] bus_addr, // Register address
   input wire logic [7:0] bus_wdata, // Write data
   input wire logic bus_wr, // Write strobe
   input wire logic bus_rd, // Read strobe
   output logic [7:0] bus_rdata, // Read data, cycle after strobe
   output logic [NUM_IN-1:0] change_flags // Flags as a level
);
   // Reset pattern and register map as typed constants
   localparam ivcf_byte_t FLAGS_RST = `IVCF_FLAGS_RST;
   localparam ivcf_byte_t ADDR_FLAGS = `IVCF_ADDR_FLAGS;
   localparam ivcf_byte_t ADDR_VALID = `IVCF_ADDR_VALID;

   // Per-input validity levels under their own names
   logic ref_input_one;
   logic ref_input_two;
   logic ref_input_three;
   logic ref_input_four;
   logic ref_input_five;
   logic ref_input_six;
   logic ref_input_seven;
   logic ref_input_eight;
   // Per-input sticky change flags
   logic ref_input_one_chg;
   logic ref_input_two_chg;
   logic ref_input_three_chg;
   logic ref_input_four_chg;
   logic ref_input_five_chg;
   logic ref_input_six_chg;
   logic ref_input_seven_chg;
   logic ref_input_eight_chg;

   // Bus request, decode and datapath
   ivcf_req_s req;
   logic [NUM_IN-1:0] flag_w;
   logic [NUM_IN-1:0] valid_w;
   logic [NUM_IN-1:0] clr_w;
   logic hit_flags;
   logic hit_valid;
   // Decoded write strobe and widened read sources
   logic wr_flags;
   ivcf_byte_t flags_byte;
   ivcf_byte_t valid_byte;
   ivcf_byte_t rd_mux;
   logic [7:0] rdata_r;
   logic [NUM_IN-1:0] flags_out_r;

   // Bundle the bus request
   assign req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr,
                  rd: bus_rd};

   // Address decode
   assign hit_flags = (req.addr == ADDR_FLAGS);
   assign hit_valid = (req.addr == ADDR_VALID);

   // Write strobe aimed at the flag register
   assign wr_flags = req.wr && hit_flags;

   // Clear pulses, one per bit written with one
   assign clr_w = wr_flags ? req.wdata[NUM_IN-1:0] : '0;

   // Split the validity vector, bit 0 is input one
   assign ref_input_one = ref_valid[0];
   assign ref_input_two = ref_valid[1];
   assign ref_input_three = ref_valid[2];
   assign ref_input_four = ref_valid[3];
   assign ref_input_five = ref_valid[4];
   assign ref_input_six = ref_valid[5];
   assign ref_input_seven = ref_valid[6];
   assign ref_input_eight = ref_valid[7];

   // Input one, flag bit 0
   ivcf_flag_bit #(
      .RST_VAL(FLAGS_RST[0])
   ) u_ref_input_one (
      .clk(clk),
      .sys_rst(sys_rst),
      .valid_in(ref_input_one),
      .clr(clr_w[0]),
      .flag(ref_input_one_chg),
      .valid_seen(valid_w[0])
   );

   // Input two, flag bit 1
   ivcf_flag_bit #(
      .RST_VAL(FLAGS_RST[1])
   ) u_ref_input_two (
      .clk(clk),
      .sys_rst(sys_rst),
      .valid_in(ref_input_two),
      .clr(clr_w[1]),
      .flag(ref_input_two_chg),
      .valid_seen(valid_w[1])
   );

   // Input three, flag bit 2
   ivcf_flag_bit #(
      .RST_VAL(FLAGS_RST[2])
   ) u_ref_input_three (
      .clk(clk),
      .sys_rst(sys_rst),
      .valid_in(ref_input_three),
      .clr(clr_w[2]),
      .flag(ref_input_three_chg),
      .valid_seen(valid_w[2])
   );

   // Input four, flag bit 3
   ivcf_flag_bit #(
      .RST_VAL(FLAGS_RST[3])
   ) u_ref_input_four (
      .clk(clk),
      .sys_rst(sys_rst),
      .valid_in(ref_input_four),
      .clr(clr_w[3]),
      .flag(ref_input_four_chg),
      .valid_seen(valid_w[3])
   );

   // Input five, flag bit 4
   ivcf_flag_bit #(
      .RST_VAL(FLAGS_RST[4])
   ) u_ref_input_five (
      .clk(clk),
      .sys_rst(sys_rst),
      .valid_in(ref_input_five),
      .clr(clr_w[4]),
      .flag(ref_input_five_chg),
      .valid_seen(valid_w[4])
   );

   // Input six, flag bit 5
   ivcf_flag_bit #(
      .RST_VAL(FLAGS_RST[5])
   ) u_ref_input_six (
      .clk(clk),
      .sys_rst(sys_rst),
      .valid_in(ref_input_six),
      .clr(clr_w[5]),
      .flag(ref_input_six_chg),
      .valid_seen(valid_w[5])
   );

   // Input seven, flag bit 6
   ivcf_flag_bit #(
      .RST_VAL(FLAGS_RST[6])
   ) u_ref_input_seven (
      .clk(clk),
      .sys_rst(sys_rst),
      .valid_in(ref_input_seven),
      .clr(clr_w[6]),
      .flag(ref_input_seven_chg),
      .valid_seen(valid_w[6])
   );

   // Input eight, flag bit 7
   ivcf_flag_bit #(
      .RST_VAL(FLAGS_RST[7])
   ) u_ref_input_eight (
      .clk(clk),
      .sys_rst(sys_rst),
      .valid_in(ref_input_eight),
      .clr(clr_w[7]),
      .flag(ref_input_eight_chg),
      .valid_seen(valid_w[7])
   );

   // Byte order of the flags: bit 7 is input eight, bit 0 input one
   assign flag_w = {ref_input_eight_chg, ref_input_seven_chg,
                    ref_input_six_chg, ref_input_five_chg,
                    ref_input_four_chg, ref_input_three_chg,
                    ref_input_two_chg, ref_input_one_chg};

   // Flags and validity widened to a byte
   assign flags_byte = ivcf_byte_t'(flag_w);
   assign valid_byte = ivcf_byte_t'(valid_w);

   // Read selection; unmapped addresses read zero
   assign rd_mux = hit_flags ? flags_byte :
                   hit_valid ? valid_byte : 8'h00;

   // Registered read data, valid only the cycle after the strobe
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= req.rd ? rd_mux : 8'h00;
      end
   end

   // Level copy of the flags for the pin
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flags_out_r <= FLAGS_RST[NUM_IN-1:0];
      end else begin
         flags_out_r <= flag_w;
      end
   end

   // Outputs straight from the registers
   assign bus_rdata = rdata_r;
   assign change_flags = flags_out_r;
endmodule
`default_nettype wire

// File: dv/ivcf_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ivcf_chk #(parameter int NUM_IN = 8) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [NUM_IN-1:0] ref_valid,
   input wire logic [7:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_rdata,
   input wire logic [NUM_IN-1:0] change_flags
);
default clocking @(posedge clk); endclocking
default disable iff (sys_rst);
a_change_sets: assert property (1 |-> &(change_flags |
   ~($past(ref_valid,2)^$past(ref_valid,3)))) else $error("flag missed");
a_clear_works: assert property (
   bus_wr && bus_addr==8'h06 && !$past(sys_rst) && !$changed(ref_valid)
   ##1 !$changed(ref_valid) |-> ##1 (change_flags & $past(bus_wdata,2))==0)
   else $error("flag not cleared");
a_read_flags: assert property ($past(bus_rd) &&
   $past(bus_addr)==8'h06 |-> bus_rdata==change_flags) else $error("bad read");
a_rdata_idle: assert property (
   !$past(bus_rd) |-> bus_rdata==8'h00) else $error("stray read data");
a_flag_holds: assert property (
   ($past(change_flags) & ~change_flags & ~(($past(bus_wr,2) &&
   $past(bus_addr,2)==8'h06) ? $past(bus_wdata,2) : 8'h00))==8'h00)
   else $error("flag dropped without clear");
a_no_false_set: assert property (
   (~$past(change_flags) & change_flags &
   ~($past(ref_valid,2)^$past(ref_valid,3)))==8'h00)
   else $error("flag set without change");
endmodule
bind ivcf_top ivcf_chk #(.NUM_IN(NUM_IN)) u_chk(.clk(clk),.sys_rst(sys_rst),
   .ref_valid(ref_valid),.bus_addr(bus_addr),.bus_wdata(bus_wdata),
   .bus_wr(bus_wr),.bus_rd(bus_rd),.bus_rdata(bus_rdata),
   .change_flags(change_flags));
`default_nettype wire

// File: dv/ivcf_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ivcf_top_tb;
import ivcf_pkg::*;
logic clk=0,sys_rst=1,wr=0,rd=0,rd_d=0;
ivcf_byte_t rv=0,a=0,wd=0,rdata,cf,e,a_d=0,m,n,o=0,q[$];
int bad_count=0,samples_checked=0,seed=32'h8541850C;
ivcf_top ivcf_top_inst(.clk(clk),.sys_rst(sys_rst),.ref_valid(rv),
   .bus_addr(a),.bus_wdata(wd),.bus_wr(wr),.bus_rd(rd),.bus_rdata(rdata),
   .change_flags(cf));
always #12.5 clk=~clk;
task automatic chk(ivcf_byte_t s,e);
   samples_checked++;
   if(s!==e) begin
      bad_count++;
      $display("mismatch %0t %h %h",$time,s,e);
   end
endtask
task automatic conclude;
   $display("checks %0d bad %0d",samples_checked,bad_count);
   if(bad_count==0&&samples_checked>0) begin
      $display("DONE - PASS");
   end else begin
      $display("DONE - FAIL");
   end
   $finish;
endtask
// One bus cycle; also sets validity levels
task automatic bus(logic w,ivcf_byte_t ad,d,e,v);
   @(posedge clk);
   {wr,rd,a,wd,rv}<={w,!w,ad,d,v};
   if(!w) q.push_back(e);
   @(posedge clk);
   {wr,rd}<=2'h0;
endtask
// Compares each read answer
always @(posedge clk) begin
   rd_d<=rd;
   a_d<=a;
   if(rd_d) begin
      e=q.pop_front();
      chk(rdata,e);
      if(a_d==8'h06) chk(cf,e);
   end
end
// Watchdog
initial begin
   repeat(5000) @(posedge clk);
   bad_count++;
   conclude;
end
initial begin
   repeat(8) @(posedge clk);
   sys_rst<=1'b0;
   bus(0,8'h06,0,8'hFF,0);
   bus(1,8'h06,8'hFF,0,0);
   bus(0,8'h06,0,0,0);
   $display("test reset_clear done");
   for(int i=0;i<8;i++) begin
      m=8'h01<<i;
      bus(1,8'h20,0,0,m);
      bus(0,8'h06,0,m,m);
      bus(1,8'h20,0,0,0);
      bus(0,8'h06,0,m,0);
      bus(1,8'h06,~m,0,0);
      bus(0,8'h06,0,m,0);
      bus(1,8'h06,m,0,0);
      bus(0,8'h06,0,0,0);
   end
   $display("test per_input done");
   repeat(8) begin
      n=ivcf_byte_t'($random(seed));
      bus(1,8'h06,8'hFF,0,n);
      bus(0,8'h06,0,n^o,n);
      o=n;
   end
   bus(0,8'h20,0,0,n);
   bus(1,8'h07,8'hFF,0,n);
   bus(0,8'h07,0,n,n);
   $display("test random_collide done");
   @(posedge clk);
   sys_rst<=1'b1;
   repeat(2) @(posedge clk);
   sys_rst<=1'b0;
   bus(0,8'h06,0,8'hFF,n);
   $display("test mid_reset done");
   repeat(3) @(posedge clk);
   conclude;
end
endmodule
`default_nettype wire
